/* hdl/scs_defs.vh */
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
// timing
`define SCS_CLK_PERIOD_NS 32'h00000008
`define SCS_CYCLES_PER_MS 17'h1E848
`define SCS_SYNC_TIMEOUT_DS 16'h0384
`define SCS_MS_NS 32'h000F4240
`define SCS_DAY_MS 32'sh05265C00
`define SCS_HALF_DAY_MS 32'sh02932E00
`define SCS_MIN_MS 32'h0000EA60
`define SCS_HALF_MIN_MS 32'h00007530
`define SCS_STEP_LIMIT_MS 32'sh00000FA0
`define SCS_HOUR_MS 32'sh0036EE80
`define SCS_ZONE_UNIT_MS 32'sh00008CA0
`define SCS_SYNC_TIMEOUT_MS 32'h00015F90
`define SCS_DECI_MS 7'h64
`define SCS_DECI_MS_W 32'h00000064
`define SCS_SLEW_DIV 4'hF
`define SCS_FILT_SHIFT 2
`define SCS_LEARN_MAX 16'hE000
`define SCS_PULSE_MIN_MS 32'h00000032
// time code
`define SCS_IRIG_LATE_MS 32'sh000003F0
`define SCS_IRIG_P_MIN_MS 4'h6
`define SCS_IRIG_ONE_MIN_MS 4'h3
`define SCS_IRIG_FRAME_END 7'h64
`define SCS_IRIG_LAST_BIT 7'h1A
`define SCS_IRIG_MARK_POS 4'h9
// register offsets
`define SCS_REG_CTRL 8'h00
`define SCS_REG_ZONE 8'h04
`define SCS_REG_OFFSET 8'h08
`define SCS_REG_AUTOADJ 8'h0C
`define SCS_REG_TIME 8'h10
`define SCS_REG_STATUS 8'h14
`define SCS_REG_RAWDEV 8'h18
`define SCS_REG_FILTDEV 8'h1C
`define SCS_REG_INT_STAT 8'h20
`define SCS_REG_INT_MASK 8'h24
// fields
`define SCS_CTRL_SEL_MSB 4
`define SCS_CTRL_SUMMER_BIT 8
`define SCS_CTRL_IRIG_BIT 9
`define SCS_CTRL_LEARN_BIT 10
`define SCS_AA_DIR_BIT 16
`define SCS_SEL_LAST 5'h18
`define SCS_INT_MODE_BIT 0
`define SCS_INT_SYNC_BIT 1
`define SCS_INT_STEP_BIT 2
// reset values
`define SCS_CTRL_RST 11'h000
`define SCS_ZONE_RST 12'h000
`define SCS_OFFSET_RST 16'h0000
`define SCS_AA_RST 16'h0000
// sync source codes
`define SCS_SRC_INT 2'h0
`define SCS_SRC_PULSE 2'h1
`define SCS_SRC_SNTP 2'h2
`define SCS_SRC_IRIG 2'h3
`endif

/* hdl/scs_irig_rx.v */
`timescale 1ns/1ns
`include "scs_defs.vh"
module scs_irig_rx #(
   parameter [16:0] CYCLES_PER_MS = `SCS_CYCLES_PER_MS
) (
   // clock and reset
   input wire mclk_i,
   input wire reset_i,
   // synchronised time code level
   input wire level_i,
   // decoded frame
   output wire frame_valid_o,
   output wire [26:0] frame_ms_o
);
   reg [16:0] presc_q;
   reg [3:0] width_q;
   reg lvl_q;
   reg prev_p_q;
   reg [6:0] idx_q;
   reg [3:0] dec_q;
   reg [26:1] bits_q;
   reg valid_q;
   reg [26:0] ms_q;
   wire ms_tick = presc_q == CYCLES_PER_MS - 17'h00001;
   wire rise = level_i & ~lvl_q;
   wire fall = lvl_q & ~level_i;
   wire is_p = width_q >= `SCS_IRIG_P_MIN_MS;
   wire is_one = width_q >= `SCS_IRIG_ONE_MIN_MS;
   // bcd fields, units first, position markers skipped
   wire [3:0] sec_u = bits_q[4:1];
   wire [3:0] sec_t = {1'b0, bits_q[8:6]};
   wire [3:0] min_u = bits_q[13:10];
   wire [3:0] min_t = {1'b0, bits_q[17:15]};
   wire [3:0] hr_u = bits_q[23:20];
   wire [3:0] hr_t = {2'b00, bits_q[26:25]};
   wire [31:0] hr_w = {28'h0000000, hr_u} + {28'h0000000, hr_t} * 32'h0000000A;
   wire [31:0] min_w = {28'h0000000, min_u} + {28'h0000000, min_t} * 32'h0000000A;
   wire [31:0] sec_w = {28'h0000000, sec_u} + {28'h0000000, sec_t} * 32'h0000000A;
   wire [31:0] tot_w = ((hr_w * 32'h0000003C + min_w) * 32'h0000003C + sec_w) * 32'h000003E8;
   wire digits_ok = sec_u <= 4'h9 && sec_t <= 4'h5 && min_u <= 4'h9 && min_t <= 4'h5 &&
                    hr_u <= 4'h9 && hr_w <= 32'h00000017;
   assign frame_valid_o = valid_q;
   assign frame_ms_o = ms_q;
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         presc_q <= 17'h00000;
         width_q <= 4'h0;
         lvl_q <= 1'b0;
         prev_p_q <= 1'b0;
         idx_q <= 7'h00;
         dec_q <= 4'h0;
         bits_q <= 26'h0000000;
         valid_q <= 1'b0;
         ms_q <= 27'h0000000;
      end else begin
         lvl_q <= level_i;
         valid_q <= 1'b0;
         // prescaler restarts on each rising edge so widths are measured from the edge
         if (rise || ms_tick) begin
            presc_q <= 17'h00000;
         end else begin
            presc_q <= presc_q + 17'h00001;
         end
         if (rise) begin
            width_q <= 4'h0;
         end else if (level_i && ms_tick && width_q != 4'hF) begin
            width_q <= width_q + 4'h1;
         end
         if (fall) begin
            prev_p_q <= is_p;
            if (is_p && prev_p_q) begin
               // two markers in a row: reference, the previous frame is complete
               valid_q <= idx_q == `SCS_IRIG_FRAME_END && digits_ok;
               ms_q <= tot_w[26:0];
               idx_q <= 7'h01;
               dec_q <= 4'h1;
            end else if (idx_q != 7'h00) begin
               if (idx_q == `SCS_IRIG_FRAME_END || is_p != (dec_q == `SCS_IRIG_MARK_POS)) begin
                  idx_q <= 7'h00;
               end else begin
                  if (!is_p && idx_q <= `SCS_IRIG_LAST_BIT) begin
                     bits_q[idx_q] <= is_one;
                  end
                  idx_q <= idx_q + 7'h01;
                  dec_q <= (dec_q == `SCS_IRIG_MARK_POS) ? 4'h0 : dec_q + 4'h1;
               end
            end
         end
      end
   end
endmodule // scs_irig_rx

/* hdl/scs_sync_top.v */
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "scs_defs.vh"
module scs_sync_top #(
   parameter [16:0] CYCLES_PER_MS = `SCS_CYCLES_PER_MS
) (
   // clock and reset
   input wire mclk_i,
   input wire reset_i,
   // apb slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output wire [31:0] prdata_o,
   output wire pready_o,
   output wire pslverr_o,
   // pulse sync sources
   input wire [7:0] dig_in_i,
   input wire [7:0] virt_in_i,
   input wire [7:0] virt_out_i,
   // network time
   input wire sntp_valid_i,
   input wire [26:0] sntp_ms_i,
   // time code pin
   input wire irig_i,
   // time and status
   output wire [26:0] time_ms_o,
   output wire ext_sync_o,
   output wire [1:0] sync_source_o,
   output wire irq_o
);
   localparam [15:0] TIMEOUT_DS = `SCS_SYNC_TIMEOUT_DS;

   function [26:0] wrap_day;
      input signed [31:0] t;
      reg signed [31:0] d;
      begin
         d = t;
         if (d < 32'sh00000000) begin
            d = d + `SCS_DAY_MS;
         end else if (d >= `SCS_DAY_MS) begin
            d = d - `SCS_DAY_MS;
         end
         wrap_day = d[26:0];
      end
   endfunction

   function addr_hit;
      input [7:0] a;
      begin
         case (a)
            `SCS_REG_CTRL, `SCS_REG_ZONE, `SCS_REG_OFFSET, `SCS_REG_AUTOADJ,
            `SCS_REG_TIME, `SCS_REG_STATUS, `SCS_REG_RAWDEV, `SCS_REG_FILTDEV,
            `SCS_REG_INT_STAT, `SCS_REG_INT_MASK: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
         endcase
      end
   endfunction

   function sel_bit;
      input [4:0] s;
      input [23:0] v;
      begin
         if (s == 5'h00 || s > `SCS_SEL_LAST) begin
            sel_bit = 1'b0;
         end else begin
            sel_bit = v[s - 5'h01];
         end
      end
   endfunction

   reg [7:0] di_m_q;
   reg [7:0] di_s_q;
   reg irig_m_q;
   reg irig_s_q;
   reg pulse_prev_q;
   reg [10:0] ctrl_q;
   reg [11:0] zone_q;
   reg [15:0] offs_q;
   reg [15:0] aa_int_q;
   reg aa_dir_q;
   reg [15:0] aa_cnt_q;
   reg [26:0] time_q;
   reg [16:0] presc_q;
   reg [6:0] deci_cnt_q;
   reg [3:0] slew_cnt_q;
   reg signed [31:0] slew_q;
   reg signed [31:0] raw_q;
   reg signed [31:0] filt_q;
   reg [15:0] since_q;
   reg ext_q;
   reg [1:0] src_q;
   reg [2:0] stat_q;
   reg [2:0] mask_q;
   reg [31:0] prdata_q;

   wire irig_ev;
   wire [26:0] irig_ms;

   scs_irig_rx #(
      .CYCLES_PER_MS(CYCLES_PER_MS)
   ) u_irig (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .level_i(irig_s_q),
      .frame_valid_o(irig_ev),
      .frame_ms_o(irig_ms)
   );

   wire ms_tick = presc_q == CYCLES_PER_MS - 17'h00001;
   wire deci_tick = ms_tick && deci_cnt_q == `SCS_DECI_MS - 7'h01;
   wire apb_wr = psel_i & penable_i & pwrite_i & addr_hit(paddr_i);
   // virtual signals are on this clock already; only the pins are synchronised
   wire pulse_now = sel_bit(ctrl_q[`SCS_CTRL_SEL_MSB:0], {virt_out_i, virt_in_i, di_s_q});
   // polarity and filter delay are set outside so this edge is the leading one
   wire pulse_ev = pulse_now & ~pulse_prev_q;
   wire irig_use = irig_ev & ctrl_q[`SCS_CTRL_IRIG_BIT];
   wire sync_ev = pulse_ev | irig_use | sntp_valid_i;
   wire timeout = since_q >= TIMEOUT_DS;
   wire signed [31:0] zone_ms = $signed({{20{zone_q[11]}}, zone_q}) * `SCS_ZONE_UNIT_MS;
   wire signed [31:0] offs_ms = $signed({{16{offs_q[15]}}, offs_q});
   wire aa_ev = deci_tick && aa_int_q != 16'h0000 && aa_cnt_q >= aa_int_q - 16'h0001;
   wire slew_go = ms_tick && slew_cnt_q == `SCS_SLEW_DIV && slew_q != 32'sh00000000;
   wire wr_time = apb_wr && paddr_i == `SCS_REG_TIME && pwdata_i < `SCS_DAY_MS;
   wire wr_aa = apb_wr && paddr_i == `SCS_REG_AUTOADJ;

   reg [31:0] rem_w;
   reg signed [31:0] base_s;
   reg signed [31:0] src_s;
   reg signed [31:0] dev_s;
   reg signed [31:0] mag_s;
   reg signed [31:0] filt_s;
   reg signed [31:0] slew_n;
   reg [1:0] kind;
   reg [1:0] inc;
   reg big;
   reg [31:0] rd_d;

   always @* begin
      rem_w = {5'h00, time_q} % `SCS_MIN_MS;
      if (pulse_ev) begin
         kind = `SCS_SRC_PULSE;
         base_s = {5'h00, time_q} - rem_w;
         if (rem_w >= `SCS_HALF_MIN_MS) begin
            base_s = base_s + `SCS_MIN_MS;
         end
      end else if (irig_use) begin
         kind = `SCS_SRC_IRIG;
         // frame time is reported one frame plus a marker after its on-time edge
         base_s = {5'h00, irig_ms} + `SCS_IRIG_LATE_MS;
      end else begin
         kind = `SCS_SRC_SNTP;
         base_s = {5'h00, sntp_ms_i} + zone_ms;
         if (ctrl_q[`SCS_CTRL_SUMMER_BIT]) begin
            base_s = base_s + `SCS_HOUR_MS;
         end
      end
      src_s = {5'h00, wrap_day(base_s + offs_ms)};
      dev_s = src_s - {5'h00, time_q};
      if (dev_s > `SCS_HALF_DAY_MS) begin
         dev_s = dev_s - `SCS_DAY_MS;
      end else if (dev_s < -`SCS_HALF_DAY_MS) begin
         dev_s = dev_s + `SCS_DAY_MS;
      end
      mag_s = (dev_s < 32'sh00000000) ? -dev_s : dev_s;
      big = mag_s >= `SCS_STEP_LIMIT_MS;
      // first message after internal mode has no history to filter against
      filt_s = ext_q ? filt_q + ((dev_s - filt_q) >>> `SCS_FILT_SHIFT) : dev_s;
      inc = 2'h1;
      slew_n = slew_q;
      if (slew_go) begin
         if (slew_q > 32'sh00000000) begin
            inc = 2'h2;
            slew_n = slew_n - 32'sh00000001;
         end else begin
            inc = 2'h0;
            slew_n = slew_n + 32'sh00000001;
         end
      end
      if (aa_ev) begin
         slew_n = aa_dir_q ? slew_n - 32'sh00000001 : slew_n + 32'sh00000001;
      end
   end

   always @* begin
      rd_d = 32'h00000000;
      case (paddr_i)
         `SCS_REG_CTRL: rd_d = {21'h000000, ctrl_q};
         `SCS_REG_ZONE: rd_d = {20'h00000, zone_q};
         `SCS_REG_OFFSET: rd_d = {16'h0000, offs_q};
         `SCS_REG_AUTOADJ: rd_d = {15'h0000, aa_dir_q, aa_int_q};
         `SCS_REG_TIME: rd_d = {5'h00, time_q};
         `SCS_REG_STATUS: rd_d = {29'h00000000, ext_q, src_q};
         `SCS_REG_RAWDEV: rd_d = raw_q;
         `SCS_REG_FILTDEV: rd_d = filt_q;
         `SCS_REG_INT_STAT: rd_d = {29'h00000000, stat_q};
         `SCS_REG_INT_MASK: rd_d = {29'h00000000, mask_q};
         default: rd_d = 32'h00000000;
      endcase
   end

   wire mode_chg = (sync_ev & ~ext_q) | (~sync_ev & ext_q & timeout);
   wire step_ev = sync_ev & big & ~wr_time;
   wire [2:0] ev = {step_ev, sync_ev, mode_chg};
   wire [2:0] clr = (apb_wr && paddr_i == `SCS_REG_INT_STAT) ? pwdata_i[2:0] : 3'h0;

   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         di_m_q <= 8'h00;
         di_s_q <= 8'h00;
         irig_m_q <= 1'b0;
         irig_s_q <= 1'b0;
         pulse_prev_q <= 1'b0;
         ctrl_q <= `SCS_CTRL_RST;
         zone_q <= `SCS_ZONE_RST;
         offs_q <= `SCS_OFFSET_RST;
         aa_int_q <= `SCS_AA_RST;
         aa_dir_q <= 1'b0;
         aa_cnt_q <= 16'h0000;
         time_q <= 27'h0000000;
         presc_q <= 17'h00000;
         deci_cnt_q <= 7'h00;
         slew_cnt_q <= 4'h0;
         slew_q <= 32'sh00000000;
         raw_q <= 32'sh00000000;
         filt_q <= 32'sh00000000;
         since_q <= 16'h0000;
         ext_q <= 1'b0;
         src_q <= `SCS_SRC_INT;
         stat_q <= 3'h0;
         mask_q <= 3'h0;
         prdata_q <= 32'h00000000;
      end else begin
         di_m_q <= dig_in_i;
         di_s_q <= di_m_q;
         irig_m_q <= irig_i;
         irig_s_q <= irig_m_q;
         pulse_prev_q <= pulse_now;
         presc_q <= ms_tick ? 17'h00000 : presc_q + 17'h00001;
         if (ms_tick) begin
            deci_cnt_q <= deci_tick ? 7'h00 : deci_cnt_q + 7'h01;
            slew_cnt_q <= slew_cnt_q + 4'h1;
         end
         if (apb_wr && paddr_i == `SCS_REG_CTRL) begin
            ctrl_q <= pwdata_i[10:0];
         end
         if (apb_wr && paddr_i == `SCS_REG_ZONE) begin
            zone_q <= pwdata_i[11:0];
         end
         if (apb_wr && paddr_i == `SCS_REG_OFFSET) begin
            offs_q <= pwdata_i[15:0];
         end
         if (apb_wr && paddr_i == `SCS_REG_INT_MASK) begin
            mask_q <= pwdata_i[2:0];
         end
         if (deci_tick) begin
            aa_cnt_q <= aa_ev ? 16'h0000 : aa_cnt_q + 16'h0001;
         end
         if (sync_ev) begin
            since_q <= 16'h0000;
         end else if (deci_tick && since_q != 16'hFFFF) begin
            since_q <= since_q + 16'h0001;
         end
         if (sync_ev) begin
            ext_q <= 1'b1;
            src_q <= kind;
         end else if (timeout) begin
            ext_q <= 1'b0;
            src_q <= `SCS_SRC_INT;
         end
         // time counter: a software set wins, then a large step, else gentle slewing
         if (wr_time) begin
            time_q <= pwdata_i[26:0];
            slew_q <= 32'sh00000000;
         end else if (sync_ev && big) begin
            time_q <= src_s[26:0];
            slew_q <= 32'sh00000000;
         end else begin
            if (ms_tick) begin
               time_q <= wrap_day({5'h00, time_q} + {30'h00000000, inc});
            end
            slew_q <= sync_ev ? filt_s : slew_n;
         end
         if (sync_ev) begin
            raw_q <= dev_s;
            filt_q <= big ? dev_s : filt_s;
         end
         // learning: shorten the interval while the error keeps its sign, stretch it when it flips
         if (wr_aa) begin
            aa_int_q <= pwdata_i[15:0];
            aa_dir_q <= pwdata_i[`SCS_AA_DIR_BIT];
         end else if (sync_ev && !big && ext_q && ctrl_q[`SCS_CTRL_LEARN_BIT] &&
                      dev_s != 32'sh00000000) begin
            if (aa_int_q == 16'h0000) begin
               aa_dir_q <= dev_s < 32'sh00000000;
               aa_int_q <= (since_q == 16'h0000) ? 16'h0001 : since_q;
            end else if (aa_dir_q != (dev_s < 32'sh00000000)) begin
               aa_int_q <= (aa_int_q >= `SCS_LEARN_MAX) ? 16'h0000 :
                           aa_int_q + (aa_int_q >> 3) + 16'h0001;
            end else begin
               aa_int_q <= aa_int_q - (aa_int_q >> 3);
            end
         end
         stat_q <= (stat_q & ~clr) | ev;
         if (psel_i && !penable_i) begin
            prdata_q <= rd_d;
         end
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i & penable_i & ~addr_hit(paddr_i);
   assign time_ms_o = time_q;
   assign ext_sync_o = ext_q;
   assign sync_source_o = src_q;
   assign irq_o = |(stat_q & mask_q);
endmodule // scs_sync_top

/* test/scs_src_model.sv */
`timescale 1ns/1ns
`include "scs_defs.vh"
module scs_src_model #(
   parameter integer MS_CYCLES = 1
) (
   // clock
   input wire mclk_i,
   // minute pulse lines
   output reg [7:0] dig_in_o,
   output reg [7:0] virt_in_o,
   output reg [7:0] virt_out_o,
   // network time
   output reg sntp_valid_o,
   output reg [26:0] sntp_ms_o,
   // time code, not fitted here so it idles low
   output reg irig_o
);
   reg req = 1'b0;
   reg [26:0] req_ms = 27'h0;
   initial begin
      dig_in_o = 8'h0;
      virt_in_o = 8'h0;
      virt_out_o = 8'h0;
      sntp_valid_o = 1'b0;
      sntp_ms_o = 27'h0;
      irig_o = 1'b0;
   end
   // stale data toggles so a late capture cannot look right by chance
   always @(posedge mclk_i) begin
      sntp_valid_o <= req;
      sntp_ms_o <= req ? req_ms : ~sntp_ms_o;
   end
   task sntp(input integer v);
      req_ms = v;
      req <= 1'b1;
      @(posedge mclk_i);
      req <= 1'b0;
   endtask
   task pulse(input integer g, input integer b);
      if (g == 0) dig_in_o[b] <= 1'b1;
      if (g == 1) virt_in_o[b] <= 1'b1;
      if (g == 2) virt_out_o[b] <= 1'b1;
      repeat (`SCS_PULSE_MIN_MS * MS_CYCLES) @(posedge mclk_i);
      dig_in_o <= 8'h0;
      virt_in_o <= 8'h0;
      virt_out_o <= 8'h0;
   endtask
endmodule // scs_src_model

/* test/scs_sync_sva.sv */
`timescale 1ns/1ns
`include "scs_defs.vh"
module scs_sync_sva #(
   parameter [16:0] CYCLES_PER_MS = `SCS_CYCLES_PER_MS
) (
   // clock and reset
   input wire mclk_i,
   input wire reset_i,
   // apb
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] prdata_o,
   input wire pready_o,
   input wire pslverr_o,
   // sync inputs
   input wire [7:0] dig_in_i,
   input wire [7:0] virt_in_i,
   input wire [7:0] virt_out_i,
   input wire sntp_valid_i,
   input wire irig_i,
   // time and status
   input wire [26:0] time_ms_o,
   input wire ext_sync_o,
   input wire [1:0] sync_source_o
);
   // two deciseconds of slack either side: the timeout timer is coarse
   // wide enough for the full-rate millisecond prescaler
   localparam [63:0] LIM_LO = 64'h0000000000015EC8 * CYCLES_PER_MS;
   localparam [63:0] LIM_HI = 64'h0000000000016058 * CYCLES_PER_MS;
   reg [63:0] quiet_q;
   reg [63:0] calm_q;
   reg [1:0] src_q;
   reg [23:0] pins_q;
   wire [23:0] pins = {dig_in_i, virt_in_i, virt_out_i};
   wire unmapped = paddr_i > `SCS_REG_INT_MASK || paddr_i[1:0] != 2'h0;
   wire resync = sntp_valid_i || sync_source_o != src_q;
   // quiet_q only restarts on visible syncs, calm_q on any pin change too
   always @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         quiet_q <= 64'h0;
         calm_q <= 64'h0;
         src_q <= 2'h0;
         pins_q <= 24'h0;
      end else begin
         src_q <= sync_source_o;
         pins_q <= pins;
         quiet_q <= resync ? 64'h0 : quiet_q + 64'h1;
         calm_q <= (resync || pins != pins_q) ? 64'h0 : calm_q + 64'h1;
      end
   end
   default clocking dc @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);
   sequence s_access;
      psel_i && penable_i;
   endsequence
   sequence s_quiet;
      (!irig_i && $stable(pins)) [*3];
   endsequence
   a_ready_high: assert property (pready_o)
      else $error("pready low");
   a_err_unmapped: assert property (pslverr_o == (psel_i && penable_i && unmapped))
      else $error("pslverr wrong");
   a_err_zero: assert property (s_access ##0 (!pwrite_i && unmapped) |-> prdata_o == 32'h0)
      else $error("unmapped read not zero");
   a_ext_src: assert property (ext_sync_o == (sync_source_o != `SCS_SRC_INT))
      else $error("mode and source disagree");
   a_sntp_src: assert property (s_quiet ##0 sntp_valid_i |=> ext_sync_o && sync_source_o == `SCS_SRC_SNTP)
      else $error("network message not shown as source");
   a_fall_late: assert property ($fell(ext_sync_o) |-> quiet_q >= LIM_LO)
      else $error("internal mode entered early");
   a_fall_bound: assert property (calm_q == LIM_HI |-> !ext_sync_o)
      else $error("internal mode entered late");
   a_time_fwd: assert property (!$past(sntp_valid_i) && !$past(psel_i && pwrite_i)
      && sync_source_o != `SCS_SRC_PULSE && $past(sync_source_o) != `SCS_SRC_PULSE
      |-> time_ms_o - $past(time_ms_o) <= 32'h2 || time_ms_o < 27'h3)
      else $error("time jumped or went back");
   a_time_range: assert property (time_ms_o < 27'h5265C00)
      else $error("time beyond one day");
endmodule // scs_sync_sva
bind scs_sync_top scs_sync_sva #(.CYCLES_PER_MS(CYCLES_PER_MS)) sva_u (
   .mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .dig_in_i(dig_in_i), .virt_in_i(virt_in_i), .virt_out_i(virt_out_i), .sntp_valid_i(sntp_valid_i),
   .irig_i(irig_i), .time_ms_o(time_ms_o), .ext_sync_o(ext_sync_o), .sync_source_o(sync_source_o));

/* test/test_system_clock_sync.sv */
`timescale 1ns/1ns
`include "scs_defs.vh"
module test_system_clock_sync;
   typedef struct {string nm; logic [31:0] e; integer tol; logic er;} scs_note_t;
   localparam integer DAY = `SCS_DAY_MS;
   localparam integer OFF = -32'sh19;
   localparam integer SHIFT = 32'h23F * `SCS_ZONE_UNIT_MS + `SCS_HOUR_MS + OFF;
   reg mclk_i = 1'b0;
   reg reset_i = 1'b1;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h0;
   reg [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire pready, pslverr, ext_sync, irq, sv, irig;
   wire [1:0] source;
   wire [26:0] time_ms, sms;
   wire [7:0] dig, vin, vout;
   scs_note_t q[$];
   scs_note_t n;
   integer mismatches = 0, checked = 0, cyc = 0, seed = 32'h6b14270e;
   integer tw = 0, cw = 0, te, ce, cp, d, dm, s, i;
   integer sel_t[0:3] = '{32'h0, 32'h1, 32'hC, 32'h18};
   integer grp_t[0:3] = '{32'h0, 32'h0, 32'h1, 32'h2};
   integer bit_t[0:3] = '{32'h0, 32'h0, 32'h3, 32'h7};
   integer tt_t[0:3] = '{32'h4F588, 32'h4F588, 32'h51C98, 32'h36D710};
   integer rn_t[0:3] = '{32'h0, 32'h493E0, 32'h57E40, 32'h36EE80};
   always #4 mclk_i = ~mclk_i;
   // one ms per clock keeps the 90 s timeout inside the run
   scs_sync_top #(.CYCLES_PER_MS(17'h1)) dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .dig_in_i(dig), .virt_in_i(vin), .virt_out_i(vout),
      .sntp_valid_i(sv), .sntp_ms_i(sms), .irig_i(irig), .time_ms_o(time_ms), .ext_sync_o(ext_sync),
      .sync_source_o(source), .irq_o(irq));
   scs_src_model #(.MS_CYCLES(1)) src_u (.mclk_i(mclk_i), .dig_in_o(dig), .virt_in_o(vin),
      .virt_out_o(vout), .sntp_valid_o(sv), .sntp_ms_o(sms), .irig_o(irig));
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task results;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc = cyc + 1;
      if (cyc > 32'h1ADB0) begin
         mismatches = mismatches + 1;
         results;
      end
   end
   // time values drift by a cycle or two with edge ordering, hence the tolerance
   always @(posedge mclk_i) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         n = q.pop_front();
         dm = prdata - n.e;
         check(n.nm, (dm <= n.tol && dm >= -n.tol) ? n.e : prdata, n.e);
         check({n.nm, " error"}, pslverr, n.er);
      end
   end
   task apb(input logic w, input [7:0] a, input [31:0] v);
      @(posedge mclk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge mclk_i);
      penable <= 1'b1;
      @(posedge mclk_i);
      while (pready !== 1'b1) @(posedge mclk_i);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input string nm, input [7:0] a, input integer e, input integer tol, input logic er);
      q.push_back('{nm, e, tol, er});
      apb(1'b0, a, 32'h0);
   endtask
   task set_time(input integer t);
      apb(1'b1, `SCS_REG_TIME, t);
      tw = t;
      cw = cyc;
   endtask
   function integer md(input integer x);
      md = ((x % DAY) + DAY) % DAY;
   endfunction
   function integer wd(input integer x);
      wd = md(x + DAY / 2) - DAY / 2;
   endfunction
   initial begin
      repeat (8) @(posedge mclk_i);
      reset_i <= 1'b0;
      for (i = 0; i < 10; i = i + 1) if (i != 4) rd("reset", i * 4, 32'h0, 32'h0, 1'b0);
      rd("unmapped", 8'h30, 32'h0, 32'h0, 1'b1);
      apb(1'b1, `SCS_REG_INT_MASK, 32'h7);
      apb(1'b1, `SCS_REG_ZONE, 32'h23F);
      apb(1'b1, `SCS_REG_OFFSET, OFF & 32'hFFFF);
      apb(1'b1, `SCS_REG_CTRL, 32'h100);
      // clock leads by 2 s: it must only slow down
      set_time(32'h000F4240);
      s = md(tw + cyc - cw + 1 - 32'h7D0);
      src_u.sntp(md(s - SHIFT));
      te = s + 32'h7D0;
      ce = cyc;
      repeat (16'h140) @(posedge mclk_i);
      rd("slow", `SCS_REG_TIME, md(te + (cyc - ce) - (cyc - ce) / 16), 32'h3, 1'b0);
      rd("status", `SCS_REG_STATUS, 32'h6, 32'h0, 1'b0);
      rd("raw", `SCS_REG_RAWDEV, -32'sh7D0, 32'h3, 1'b0);
      rd("filt", `SCS_REG_FILTDEV, -32'sh7D0, 32'h3, 1'b0);
      rd("int", `SCS_REG_INT_STAT, 32'h3, 32'h0, 1'b0);
      apb(1'b1, `SCS_REG_INT_STAT, 32'h7);
      // random far-off network time: the clock steps
      d = $random(seed) & 32'h03FFFFFF;
      s = md(d + SHIFT);
      // the clock is still slowed by the first message, one ms in sixteen
      te = md(te + cyc - ce + 1 - (cyc - ce) / 16);
      src_u.sntp(d);
      d = wd(s - te);
      ce = cyc;
      rd("step", `SCS_REG_TIME, md(s + cyc - ce), 32'h3, 1'b0);
      rd("raw2", `SCS_REG_RAWDEV, d, 32'h3, 1'b0);
      rd("filt2", `SCS_REG_FILTDEV, d, 32'h3, 1'b0);
      rd("int2", `SCS_REG_INT_STAT, 32'h6, 32'h0, 1'b0);
      check("irq", irq, 1'b1);
      apb(1'b1, `SCS_REG_INT_MASK, 32'h0);
      @(posedge mclk_i);
      check("irq masked", irq, 1'b0);
      apb(1'b1, `SCS_REG_INT_STAT, 32'h7);
      apb(1'b1, `SCS_REG_INT_MASK, 32'h7);
      @(posedge mclk_i);
      check("irq cleared", irq, 1'b0);
      // learning on: a 100 ms lag seeds a lag interval, the filter averages
      apb(1'b1, `SCS_REG_CTRL, 32'h500);
      src_u.sntp(md(s + cyc - ce + 32'h64 - SHIFT));
      rd("learn", `SCS_REG_AUTOADJ, 32'h1, 32'h0, 1'b0);
      rd("filt3", `SCS_REG_FILTDEV, d + ((32'sh64 - d) >>> 2), 32'h3, 1'b0);
      apb(1'b1, `SCS_REG_AUTOADJ, 32'h0);
      // minute pulses: none selected, digital, virtual input, virtual output
      for (i = 0; i < 4; i = i + 1) begin
         apb(1'b1, `SCS_REG_CTRL, 32'h100 | sel_t[i]);
         set_time(tt_t[i]);
         ce = cyc;
         src_u.pulse(grp_t[i], bit_t[i]);
         te = (i == 0) ? md(tw + cyc - cw) : md(rn_t[i] + OFF + cyc - ce - 3);
         rd("minute", `SCS_REG_TIME, te, 32'h4, 1'b0);
         rd("pulse src", `SCS_REG_STATUS, (i == 0) ? 32'h6 : 32'h5, 32'h0, 1'b0);
      end
      cp = ce + 3;
      apb(1'b1, `SCS_REG_INT_STAT, 32'h7);
      // auto adjust every 100 ms: lag adds, lead holds back
      for (i = 0; i < 2; i = i + 1) begin
         apb(1'b1, `SCS_REG_AUTOADJ, (i << 16) | 1);
         set_time(32'h000F4240);
         repeat (16'h640) @(posedge mclk_i);
         rd("adjust", `SCS_REG_TIME, md(tw + cyc - cw + (i ? -16 : 16)), 32'h3, 1'b0);
      end
      rd("adjust reg", `SCS_REG_AUTOADJ, 32'h10001, 32'h0, 1'b0);
      apb(1'b1, `SCS_REG_AUTOADJ, 32'h0);
      while (cyc < cp + 32'h15BA8) @(posedge mclk_i);
      rd("still ext", `SCS_REG_STATUS, 32'h5, 32'h0, 1'b0);
      d = 0;
      while (ext_sync !== 1'b0 && d < 32'h7D0) begin
         @(posedge mclk_i);
         d = d + 1;
      end
      check("timeout", cyc - cp > 32'h15EC8 && cyc - cp < 32'h16058, 1'b1);
      rd("internal", `SCS_REG_STATUS, 32'h0, 32'h0, 1'b0);
      rd("int mode", `SCS_REG_INT_STAT, 32'h1, 32'h0, 1'b0);
      check("irq mode", irq, 1'b1);
      results;
   end
endmodule // test_system_clock_sync
